/* hdl/edge_detector.sv */
// edge detector for the external request pins
`timescale 1ns/1ps
module edge_detector
  import vip_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input edge_sel_t sel,
  output logic hit
);
  logic sync1_r, sync1_nxt;
  logic sync2_r, sync2_nxt;
  logic prev_r, prev_nxt;
  logic rise, fall;

  always_comb begin
    sync1_nxt = pin;
    sync2_nxt = sync1_r;
    prev_nxt = sync2_r;
    rise = sync2_r & ~prev_r;
    fall = ~sync2_r & prev_r;
    case (sel)
      edge_rising: hit = rise;
      edge_falling: hit = fall;
      edge_both: hit = rise | fall;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r <= prev_nxt;
    end
  end
endmodule : edge_detector

/* hdl/vectored_interrupt_priority.sv */
// vectored interrupt unit: request flags, masking, priority and vector
`timescale 1ns/1ps
module vectored_interrupt_priority
  import vip_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input source_events_t events,
  input wire logic [num_pins-1:0] edge_pins,
  input edge_sel_t edge_sel_0,
  input edge_sel_t edge_sel_1,
  input edge_sel_t edge_sel_2,
  input wire logic global_request_enable,
  input wire logic [num_maskable-1:0] source_mask_flag,
  input wire logic [num_maskable-1:0] flag_clear,
  input wire logic nmi_ack,
  input wire logic grant_ack,
  output grant_t grant,
  output logic [num_maskable-1:0] request_flags,
  output logic watchdog_overflow_request
);
  logic [num_maskable-1:0] flags_r, flags_nxt;
  logic [num_maskable-1:0] set_ev;
  logic [num_maskable-1:0] eligible;
  logic nmi_r, nmi_nxt;
  grant_t grant_r, grant_nxt;
  logic [num_pins-1:0] pin_hit;
  edge_sel_t sel_arr [num_pins];

  assign sel_arr[0] = edge_sel_0;
  assign sel_arr[1] = edge_sel_1;
  assign sel_arr[2] = edge_sel_2;

  genvar g;
  generate
    for (g = 0; g < num_pins; g++) begin : pins
      edge_detector u_det (
        .clk(clk),
        .rst(rst),
        .pin(edge_pins[g]),
        .sel(sel_arr[g]),
        .hit(pin_hit[g])
      );
    end
  endgenerate

  // bit index equals priority level, so bit 0 ranks highest
  function automatic logic [15:0] level_vector(input logic [3:0] lvl);
    case (lvl)
      4'h0: level_vector = vec_watchdog;
      4'h1: level_vector = vec_edge_0;
      4'h2: level_vector = vec_edge_1;
      4'h3: level_vector = vec_edge_2;
      4'h4: level_vector = vec_serial_rx;
      4'h5: level_vector = vec_serial_tx;
      4'h6: level_vector = vec_timer8;
      4'h7: level_vector = vec_timer16;
      4'h8: level_vector = vec_convert;
      default: level_vector = 16'h0000;
    endcase
  endfunction : level_vector

  always_comb begin
    set_ev[0] = events.watchdog_overflow & ~events.watchdog_mode_1;
    set_ev[3:1] = pin_hit;
    // serial mode picks which completion counts
    set_ev[4] = events.serial_sync_mode ? events.sync_transfer_done : events.async_receive_done;
    set_ev[5] = events.async_transmit_done;
    set_ev[6] = events.eight_bit_timer_match;
    set_ev[7] = events.sixteen_bit_timer_match;
    set_ev[8] = events.conversion_done;
    // set wins over a clear in the same cycle
    flags_nxt = (flags_r & ~flag_clear) | set_ev;
    // non-maskable stays until the core takes it
    nmi_nxt = (nmi_r & ~nmi_ack) | (events.watchdog_overflow & events.watchdog_mode_1);
    eligible = flags_r & ~source_mask_flag & {num_maskable{global_request_enable}};
    grant_nxt = '0;
    if (nmi_r) begin
      // bypasses mask and global enable
      grant_nxt.valid = 1'b1;
      grant_nxt.non_maskable = 1'b1;
      grant_nxt.vector = vec_watchdog;
    end else begin
      for (int i = num_maskable - 1; i >= 0; i--) begin
        if (eligible[i]) begin
          grant_nxt.valid = 1'b1;
          grant_nxt.level = 4'(i);
          grant_nxt.vector = level_vector(4'(i));
        end
      end
    end
    if (grant_ack) begin
      // taken flag is cleared by the core; suppress the stale grant for a cycle
      grant_nxt.valid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_r <= flags_reset;
      nmi_r <= 1'b0;
      grant_r <= '0;
    end else begin
      flags_r <= flags_nxt;
      nmi_r <= nmi_nxt;
      grant_r <= grant_nxt;
    end
  end

  assign grant = grant_r;
  assign request_flags = flags_r;
  assign watchdog_overflow_request = nmi_r;
endmodule : vectored_interrupt_priority

/* hdl/vip_pkg.sv */
// package: constants and types of the vectored interrupt priority unit
// Notes on behaviour
// - watchdog overflow in watchdog mode raises non-maskable request, vector 0004H
// - watchdog overflow in interval mode raises maskable level 0, same vector
// - three edge pins raise levels 1, 2, 3 with vectors 0006H, 0008H, 000AH
// - each pin edge selectable: rising, falling or both
// - async receive or sync transfer done share level 4, vector 000CH, by mode
// - async transmit done raises level 5, vector 000EH
// - eight-bit timer match raises level 6, vector 0010H
// - sixteen-bit timer match raises level 7, vector 0012H
// - conversion done raises level 8, lowest, vector 0014H
// - simultaneous maskable requests: smallest level number wins
package vip_pkg;
  localparam int num_maskable = 9;
  localparam int num_pins = 3;
  localparam logic [15:0] vec_watchdog = 16'h0004;
  localparam logic [15:0] vec_edge_0 = 16'h0006;
  localparam logic [15:0] vec_edge_1 = 16'h0008;
  localparam logic [15:0] vec_edge_2 = 16'h000a;
  localparam logic [15:0] vec_serial_rx = 16'h000c;
  localparam logic [15:0] vec_serial_tx = 16'h000e;
  localparam logic [15:0] vec_timer8 = 16'h0010;
  localparam logic [15:0] vec_timer16 = 16'h0012;
  localparam logic [15:0] vec_convert = 16'h0014;
  localparam logic [8:0] flags_reset = 9'h000;
  localparam logic [8:0] mask_reset = 9'h1ff;

  typedef enum logic [1:0] {
    edge_rising = 2'h0,
    edge_falling = 2'h1,
    edge_both = 2'h2
  } edge_sel_t;

  typedef struct packed {
    logic watchdog_overflow;
    logic watchdog_mode_1;
    logic async_receive_done;
    logic sync_transfer_done;
    logic serial_sync_mode;
    logic async_transmit_done;
    logic eight_bit_timer_match;
    logic sixteen_bit_timer_match;
    logic conversion_done;
  } source_events_t;

  typedef struct packed {
    logic valid;
    logic non_maskable;
    logic [3:0] level;
    logic [15:0] vector;
  } grant_t;
endpackage : vip_pkg

/* test/core_model.sv */
// core model: acknowledges each grant when allowed to
`timescale 1ns/1ps
module core_model
  import vip_pkg::*;
(
  input wire logic clk,
  input wire logic take,
  input grant_t grant,
  output logic [8:0] flag_clear,
  output logic nmi_ack,
  output logic grant_ack
);
  logic hit;
  // take low models a core busy elsewhere
  always @(negedge clk) begin
    hit = take && grant.valid;
    grant_ack <= hit;
    nmi_ack <= hit && grant.non_maskable;
    flag_clear <= (hit && !grant.non_maskable) ? 9'h001 << grant.level : 9'h000;
  end
endmodule : core_model

/* test/vectored_interrupt_priority_tb_top.sv */
// testbench: fires sources and checks granted levels and vectors
`timescale 1ns/1ps
module vectored_interrupt_priority_tb_top;
  import vip_pkg::*;
  logic clk, rst, gen, take, nack, gack, wreq;
  logic [2:0] pins;
  logic [8:0] mask, fclr, flags;
  source_events_t ev;
  edge_sel_t sel;
  grant_t g;
  int bad_count, checks;
  vectored_interrupt_priority dut (.clk(clk), .rst(rst), .events(ev), .edge_pins(pins), .edge_sel_0(sel),
    .edge_sel_1(sel), .edge_sel_2(sel), .global_request_enable(gen), .source_mask_flag(mask), .flag_clear(fclr),
    .nmi_ack(nack), .grant_ack(gack), .grant(g), .request_flags(flags), .watchdog_overflow_request(wreq));
  core_model core (.clk(clk), .take(take), .grant(g), .flag_clear(fclr), .nmi_ack(nack), .grant_ack(gack));
  function automatic grant_t gr(int l);
    return {2'h2, 4'(l), 16'h0004 + 16'(2 * l)};
  endfunction : gr
  task close_out;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  task expect_grant(grant_t e);
    grant_t s;
    s = '0;
    for (int i = 0; i < 12 && s.valid !== 1'b1; i++) begin
      @(negedge clk);
      s = g;
    end
    if (s.non_maskable === 1'b1) s.level = 4'h0;
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR grant expected %h seen %h", e, s);
      if (s.valid !== e.valid) close_out;
    end
  endtask : expect_grant
  task expect_pending(logic [9:0] e);
    checks++;
    if ({wreq, flags} !== e) begin
      bad_count++;
      $display("ERROR pending expected %h seen %h", e, {wreq, flags});
    end
  endtask : expect_pending
  task fire(logic [8:0] w);
    ev = w;
    @(negedge clk);
    ev = '0;
  endtask : fire
  task automatic t_each;
    logic [8:0] w[8] = '{9'h100, 9'h040, 9'h030, 9'h008, 9'h004, 9'h002, 9'h001, 9'h180};
    int l[8] = '{0, 4, 4, 5, 6, 7, 8, 0};
    for (int i = 0; i < 8; i++) begin
      fire(w[i]);
      expect_grant(i < 7 ? gr(l[i]) : grant_t'({2'h3, 4'h0, 16'h0004}));
    end
  endtask : t_each
  task t_pins;
    // code 3 selects no edge at all
    for (int s = 0; s < 4; s++) for (int p = 0; p < 3; p++) begin
      sel = edge_sel_t'(s);
      pins[p] = 1'b1;
      expect_grant(s == 0 || s == 2 ? gr(p + 1) : '0);
      pins[p] = 1'b0;
      expect_grant(s == 1 || s == 2 ? gr(p + 1) : '0);
    end
  endtask : t_pins
  task automatic t_prio;
    int l[6] = '{0, 4, 5, 6, 7, 8};
    // nonblocking: the core model samples take on this same falling edge
    take <= 1'b0;
    fire(9'h14f);
    expect_grant(gr(0));
    mask = 9'h001;
    expect_grant(gr(4));
    gen = 0;
    expect_grant('0);
    expect_pending(10'h1f1);
    fire(9'h180);
    expect_grant({2'h3, 4'h0, 16'h0004});
    expect_pending(10'h3f1);
    {take, gen, mask} <= {2'h3, 9'h000};
    expect_grant({2'h3, 4'h0, 16'h0004});
    for (int i = 0; i < 6; i++) expect_grant(gr(l[i]));
  endtask : t_prio
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst, gen, take, pins, mask} = {3'h7, 12'h000};
    ev = '0;
    sel = edge_rising;
    repeat (6) @(negedge clk);
    rst = 0;
    t_each;
    t_pins;
    t_prio;
    close_out;
  end
endmodule : vectored_interrupt_priority_tb_top

/* test/vip_sva.sv */
// checker: port assertions of the interrupt unit
`timescale 1ns/1ps
module vip_sva
  import vip_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input source_events_t events,
  input wire logic global_request_enable,
  input wire logic [num_maskable-1:0] source_mask_flag,
  input wire logic grant_ack,
  input grant_t grant,
  input wire logic [num_maskable-1:0] request_flags,
  input wire logic watchdog_overflow_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic mg;
  logic [8:0] live_nxt, live_r;
  assign mg = grant.valid && !grant.non_maskable;
  assign live_nxt = request_flags & ~source_mask_flag & {9{global_request_enable}};
  // grant is registered, so judge it against the previous cycle's live flags
  always_ff @(posedge clk) begin
    live_r <= live_nxt;
  end
  sequence s_nmi;
    events.watchdog_overflow && events.watchdog_mode_1;
  endsequence
  a_conv_flag: assert property (events.conversion_done |=> request_flags[8]) else $error("no level 8 flag");
  a_tx_flag: assert property (events.async_transmit_done |=> request_flags[5]) else $error("no level 5 flag");
  a_wdt_level0: assert property (events.watchdog_overflow && !events.watchdog_mode_1 |=> request_flags[0])
    else $error("no level 0 flag");
  a_nmi_path: assert property (s_nmi |=> watchdog_overflow_request ##1 grant.non_maskable && grant.vector == 16'h0004)
    else $error("nmi path broken");
  a_vec_map: assert property (mg |-> grant.vector == 16'h0004 + {grant.level, 1'b0}) else $error("bad vector");
  a_gate_live: assert property (mg |-> live_r[grant.level]) else $error("gated grant");
  a_prio_order: assert property (mg |-> (live_r & ((9'h001 << grant.level) - 9'h001)) == 9'h000)
    else $error("lower level won");
  a_nmi_bypass: assert property (watchdog_overflow_request && !grant_ack |=> grant.valid && grant.non_maskable)
    else $error("nmi not granted");
endmodule : vip_sva
bind vectored_interrupt_priority vip_sva chk (.*);
